// [sadc_pkg.sv]
// sadc_pkg: shared constants for the serial converter frame controller
package sadc_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int RESULT_W = 10;
  localparam int FRAME_W = 16;
  localparam int CNT_W = 5;
  localparam int FIFO_DEPTH = 16;

  // ****************************************************************
  // frame edge counts
  // ****************************************************************
  localparam logic [CNT_W-1:0] FRAME_FALLS = 5'h10;
  localparam logic [CNT_W-1:0] TRACK_RISE = 5'h0d;
  localparam logic [CNT_W-1:0] MODE_FALL = 5'h0a;
  localparam logic [CNT_W-1:0] NOISE_FALL = 5'h02;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;
  localparam int LEAD_ZEROS = 3;
  localparam int TRAIL_ZEROS = 2;
  // pad bit after the trailing zeros, driven after fall fifteen and read by the host on rise sixteen
  localparam int PAD_BITS = 1;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic RST_PIN_LEVEL = 1'b1;
  localparam logic RST_OE_N = 1'b1;
  localparam logic RST_SHUTDOWN = 1'b0;
  localparam logic RST_POWERED = 1'b0;
  localparam logic [CNT_W-1:0] RST_CNT = 5'h00;
  localparam logic [RESULT_W-1:0] RST_SAMPLE = 10'h000;

  typedef enum logic [1:0] {
    st_idle,
    st_convert,
    st_wait_high
  } sadc_state_e;

  // saturating edge counter step
  function automatic logic [CNT_W-1:0] sadc_inc(input logic [CNT_W-1:0] c);
    sadc_inc = (c == CNT_MAX) ? c : c + 5'h01;
  endfunction

endpackage

// [sadc_fifo.sv]
// sadc_fifo: synchronous valid/ready fifo for converter samples
`timescale 1ns/1ps
`default_nettype none
module sadc_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic in_ready_ff;

  wire do_push = in_valid & in_ready_ff;
  wire do_pop = out_ready & (count_ff != '0);
  wire [AW:0] nxt_count = count_ff + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
  // ready is registered so the top's output stays a flop
  wire nxt_in_ready = (nxt_count != (AW+1)'(DEPTH));

  assign in_ready = in_ready_ff;
  assign out_valid = (count_ff != '0);
  assign out_data = mem[rd_ptr_ff];

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      in_ready_ff <= 1'b1;
    end else begin
      wr_ptr_ff <= do_push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
      rd_ptr_ff <= do_pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
      count_ff <= nxt_count;
      in_ready_ff <= nxt_in_ready;
    end
  end

endmodule
`default_nettype wire

// [sadc_frame_ctrl.sv]
// sadc_frame_ctrl: frame sequencing, serial result and power mode of the converter
//
// Contract
// - frame select fall: sample, hold, drive output
// - back to track on rising edge thirteen
// - float output after fall sixteen or select rise
// - sixteen cycles: three zeros, ten bits, zeros
// - change on falling edge, host samples rising
// - select fall enters normal mode, starts conversion
// - rise between fall two and fall ten means shutdown
// - shutdown holds until next select fall
// - rise between ten and sixteen aborts, stays normal
// - rise before fall two keeps mode unchanged
// - first result after shutdown or power-on invalid
`timescale 1ns/1ps
`default_nettype none
module sadc_frame_ctrl #(
  parameter int FIFO_WIDTH = sadc_pkg::RESULT_W,
  parameter int FIFO_DEPTH = sadc_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // host pins
  input wire logic frame_sel_n,
  input wire logic sclk,
  output logic serial_result_out,
  output logic serial_result_oe_n,
  // converter sample stream
  input wire logic sample_valid,
  input wire logic [sadc_pkg::RESULT_W-1:0] sample_data,
  output logic sample_ready,
  // status
  output logic hold_active,
  output logic normal_mode,
  output logic result_invalid,
  output logic frame_done,
  output logic frame_abort,
  output logic sample_missed
);
  import sadc_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic cs_s1_ff, cs_s2_ff, cs_s3_ff, cs_lvl_ff;
  logic ck_s1_ff, ck_s2_ff, ck_s3_ff, ck_lvl_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_s1_ff <= RST_PIN_LEVEL;
      cs_s2_ff <= RST_PIN_LEVEL;
      cs_s3_ff <= RST_PIN_LEVEL;
      ck_s1_ff <= RST_PIN_LEVEL;
      ck_s2_ff <= RST_PIN_LEVEL;
      ck_s3_ff <= RST_PIN_LEVEL;
    end else begin
      cs_s1_ff <= frame_sel_n;
      cs_s2_ff <= cs_s1_ff;
      cs_s3_ff <= cs_s2_ff;
      ck_s1_ff <= sclk;
      ck_s2_ff <= ck_s1_ff;
      ck_s3_ff <= ck_s2_ff;
    end
  end

  // a level only counts once two stages agree, filtering glitches
  wire cs_new = (cs_s2_ff == cs_s3_ff) ? cs_s3_ff : cs_lvl_ff;
  wire ck_new = (ck_s2_ff == ck_s3_ff) ? ck_s3_ff : ck_lvl_ff;
  wire cs_fall = cs_lvl_ff & ~cs_new;
  wire cs_rise = ~cs_lvl_ff & cs_new;
  wire ck_rise = ~ck_lvl_ff & ck_new;
  wire ck_fall = ck_lvl_ff & ~ck_new;

  // ****************************************************************
  // frame state and edge counters
  // ****************************************************************
  sadc_state_e state_ff, nxt_state;
  logic [CNT_W-1:0] rise_cnt_ff, fall_cnt_ff;
  logic [CNT_W-1:0] nxt_rise_cnt, nxt_fall_cnt;

  // sclk edges only count in st_convert, from the select fall until fall sixteen or a select rise
  wire in_frame = (state_ff == st_convert);
  wire cnt_rise = in_frame & ~cs_rise & ck_rise;
  wire cnt_fall = in_frame & ~cs_rise & ck_fall;
  wire last_fall = cnt_fall & (sadc_inc(fall_cnt_ff) == FRAME_FALLS);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      st_idle: begin
        if (cs_fall) begin
          nxt_state = st_convert;
        end
      end
      st_convert: begin
        if (cs_rise) begin
          nxt_state = st_idle;
        end else if (last_fall) begin
          nxt_state = st_wait_high;
        end
      end
      st_wait_high: begin
        // a new frame needs a fresh fall, so the line must rise first
        if (cs_rise) begin
          nxt_state = st_idle;
        end
      end
      default: begin
        nxt_state = st_idle;
      end
    endcase
  end

  always_comb begin
    nxt_rise_cnt = rise_cnt_ff;
    nxt_fall_cnt = fall_cnt_ff;
    if (cs_fall) begin
      nxt_rise_cnt = RST_CNT;
      nxt_fall_cnt = RST_CNT;
    end else begin
      if (cnt_rise) begin
        nxt_rise_cnt = sadc_inc(rise_cnt_ff);
      end
      if (cnt_fall) begin
        nxt_fall_cnt = sadc_inc(fall_cnt_ff);
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_lvl_ff <= RST_PIN_LEVEL;
      ck_lvl_ff <= RST_PIN_LEVEL;
      state_ff <= st_idle;
      rise_cnt_ff <= RST_CNT;
      fall_cnt_ff <= RST_CNT;
    end else begin
      cs_lvl_ff <= cs_new;
      ck_lvl_ff <= ck_new;
      state_ff <= nxt_state;
      rise_cnt_ff <= nxt_rise_cnt;
      fall_cnt_ff <= nxt_fall_cnt;
    end
  end

  // ****************************************************************
  // sample capture
  // ****************************************************************
  logic fifo_valid;
  logic [RESULT_W-1:0] fifo_data;
  logic [RESULT_W-1:0] sample_ff;

  // a sample is taken only at a frame start, so the fifo fills between frames
  wire take = cs_fall & (state_ff == st_idle);
  wire pop = take & fifo_valid;
  // on underrun the previous sample is repeated
  wire [RESULT_W-1:0] held = fifo_valid ? fifo_data : sample_ff;
  wire [FRAME_W-1:0] frame_word = {{LEAD_ZEROS{1'b0}}, held, {TRAIL_ZEROS{1'b0}},
    {PAD_BITS{1'b0}}};

  sadc_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(sample_valid),
    .in_data(sample_data),
    .in_ready(sample_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(pop)
  );

  // ****************************************************************
  // serial result shifter and output enable
  // ****************************************************************
  logic [FRAME_W-1:0] shift_ff;
  logic sdo_ff, oe_n_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sample_ff <= RST_SAMPLE;
      shift_ff <= '0;
      sdo_ff <= 1'b0;
      oe_n_ff <= RST_OE_N;
    end else begin
      if (take) begin
        sample_ff <= held;
        sdo_ff <= frame_word[FRAME_W-1];
        shift_ff <= {frame_word[FRAME_W-2:0], 1'b0};
        oe_n_ff <= 1'b0;
      end else if (cs_rise | last_fall) begin
        oe_n_ff <= 1'b1;
      end else if (cnt_fall) begin
        // msb first, one bit per falling edge; host samples on the rise
        sdo_ff <= shift_ff[FRAME_W-1];
        shift_ff <= {shift_ff[FRAME_W-2:0], 1'b0};
      end
    end
  end

  // ****************************************************************
  // track/hold and power mode
  // ****************************************************************
  logic hold_ff, shutdown_ff, prev_shutdown_ff, powered_ff, invalid_ff;
  logic done_ff, abort_ff, missed_ff;

  wire early_rise = cs_rise & in_frame & (fall_cnt_ff < NOISE_FALL);
  wire sleep_rise = cs_rise & in_frame & (fall_cnt_ff >= NOISE_FALL) & (fall_cnt_ff < MODE_FALL);
  wire trunc_rise = cs_rise & in_frame & (fall_cnt_ff >= MODE_FALL);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_ff <= 1'b0;
      shutdown_ff <= RST_SHUTDOWN;
      prev_shutdown_ff <= RST_SHUTDOWN;
      powered_ff <= RST_POWERED;
      invalid_ff <= 1'b1;
      done_ff <= 1'b0;
      abort_ff <= 1'b0;
      missed_ff <= 1'b0;
    end else begin
      done_ff <= last_fall;
      abort_ff <= cs_rise & in_frame;
      missed_ff <= take & ~fifo_valid;
      if (take) begin
        hold_ff <= 1'b1;
      end else if ((cnt_rise & (sadc_inc(rise_cnt_ff) == TRACK_RISE)) | (cs_rise & in_frame)) begin
        // an aborted conversion also releases the hold capacitor
        hold_ff <= 1'b0;
      end
      if (take) begin
        prev_shutdown_ff <= shutdown_ff;
        shutdown_ff <= 1'b0;
        // powering up burns this frame as a dummy conversion
        invalid_ff <= shutdown_ff | ~powered_ff;
        powered_ff <= 1'b1;
      end else if (early_rise) begin
        shutdown_ff <= prev_shutdown_ff;
        powered_ff <= ~prev_shutdown_ff;
      end else if (sleep_rise) begin
        shutdown_ff <= 1'b1;
        powered_ff <= 1'b0;
      end else if (trunc_rise) begin
        shutdown_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign serial_result_out = sdo_ff;
  assign serial_result_oe_n = oe_n_ff;
  assign hold_active = hold_ff;
  assign normal_mode = ~shutdown_ff;
  assign result_invalid = invalid_ff;
  assign frame_done = done_ff;
  assign frame_abort = abort_ff;
  assign sample_missed = missed_ff;

endmodule
`default_nettype wire

// [sadc_frame_ctrl_checker.sv]
// sadc_frame_ctrl_checker: pin timing assertions for the frame controller
`timescale 1ns/1ps
`default_nettype none
module sadc_frame_ctrl_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pins and status
  input wire logic frame_sel_n,
  input wire logic sclk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe_n,
  input wire logic hold_active,
  input wire logic normal_mode,
  input wire logic frame_done,
  input wire logic frame_abort
);
  import sadc_pkg::*;
  logic [CNT_W-1:0] rises_ff;
  logic [CNT_W-1:0] falls_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ****
  // raw edge counts, cleared at frame start
  // ****
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rises_ff <= RST_CNT;
      falls_ff <= RST_CNT;
    end else if ($fell(frame_sel_n)) begin
      rises_ff <= RST_CNT;
      falls_ff <= RST_CNT;
    end else begin
      if ($rose(sclk)) rises_ff <= rises_ff + 5'h01;
      if ($fell(sclk)) falls_ff <= falls_ff + 5'h01;
    end
  end
  // ****
  // assertions
  // ****
  a_start_drives_out: assert property ($fell(frame_sel_n) |-> ##[2:6]
    (!serial_result_oe_n && hold_active && normal_mode)) else $error("start not seen");
  a_rise_floats: assert property ($rose(frame_sel_n) |-> ##[2:6] serial_result_oe_n)
    else $error("output not floated");
  a_idle_floats: assert property (frame_sel_n [*8] |-> serial_result_oe_n)
    else $error("output driven while idle");
  a_hold_till_13: assert property ((!frame_sel_n && !serial_result_oe_n
    && rises_ff <= 5'h0c) |-> hold_active) else $error("hold dropped early");
  a_track_at_13: assert property (($rose(sclk) && rises_ff == 5'h0c && !frame_sel_n)
    |-> ##[2:6] !hold_active) else $error("no track after rise 13");
  a_done_at_16: assert property (frame_done |-> (serial_result_oe_n && !frame_sel_n
    && falls_ff == 5'h10)) else $error("done not at fall 16");
  a_mid_rise_off: assert property (($rose(frame_sel_n) && falls_ff >= 5'h02
    && falls_ff <= 5'h09) |-> ##[2:6] (!normal_mode && frame_abort)) else $error("no shutdown");
  a_late_rise_on: assert property (($rose(frame_sel_n) && falls_ff >= 5'h0a
    && falls_ff <= 5'h0f) |-> ##[2:6] (normal_mode && frame_abort)) else $error("late abort");
  a_mode_kept: assert property (frame_sel_n [*8] |-> $stable(normal_mode))
    else $error("mode changed while idle");
  a_out_on_fall: assert property ($changed(serial_result_out) |-> !sclk)
    else $error("bit changed while sclk high");
  a_lead_zeros: assert property ((!serial_result_oe_n && !frame_sel_n
    && falls_ff <= 5'h02) |-> !serial_result_out) else $error("leading bit not zero");
endmodule
bind sadc_frame_ctrl sadc_frame_ctrl_checker sadc_frame_ctrl_checker_inst (.clk, .reset_n,
  .frame_sel_n, .sclk, .serial_result_out, .serial_result_oe_n, .hold_active,
  .normal_mode, .frame_done, .frame_abort);
`default_nettype wire

// [sadc_host_model.sv]
// sadc_host_model: serial host that frames the converter and captures words
`timescale 1ns/1ps
`default_nettype none
module sadc_host_model (
  // clock
  input wire logic clk,
  // link pins
  output logic frame_sel_n,
  output logic sclk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe_n
);
  logic [15:0] word;
  initial begin
    frame_sel_n = 1'b1;
    sclk = 1'b0;
    word = 16'h0000;
  end
  // ****
  // one frame of n sclk cycles, fewer than 16 aborts it
  // ****
  task automatic frame(input int n);
    @(posedge clk);
    #3;
    frame_sel_n = 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      // sclk idles low, so rise 1 takes the first zero; released line reads inverted
      word = {word[14:0], serial_result_oe_n ? ~word[0] : serial_result_out};
      #60;
      sclk = 1'b0;
      #100;
    end
    #100;
    frame_sel_n = 1'b1;
    #400;
  endtask
endmodule
`default_nettype wire

// [sadc_frame_ctrl_test.sv]
// sadc_frame_ctrl_test: self-checking bench for the frame controller
`timescale 1ns/1ps
`default_nettype none
module sadc_frame_ctrl_test;
  import sadc_pkg::*;
  logic clk;
  logic reset_n;
  logic sample_valid;
  logic [RESULT_W-1:0] sample_data;
  logic frame_sel_n, sclk, serial_result_out, serial_result_oe_n, sample_ready;
  logic hold_active, normal_mode, result_invalid, frame_done, frame_abort, sample_missed;
  int n_fail, check_count, n_done, n_abort, n_miss;
  sadc_host_model sadc_host_model_inst (.clk, .frame_sel_n, .sclk, .serial_result_out,
    .serial_result_oe_n);
  sadc_frame_ctrl sadc_frame_ctrl_inst (.clk, .reset_n, .frame_sel_n, .sclk,
    .serial_result_out, .serial_result_oe_n, .sample_valid, .sample_data, .sample_ready,
    .hold_active, .normal_mode, .result_invalid, .frame_done, .frame_abort, .sample_missed);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    n_done += (frame_done === 1'b1);
    n_abort += (frame_abort === 1'b1);
    n_miss += (sample_missed === 1'b1);
  end
  // ****
  // helpers
  // ****
  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  // fill the fifo until it refuses, then drain one word per frame
  task automatic test_stream();
    int n;
    logic [RESULT_W-1:0] d;
    n = 0;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      #3;
      if (sample_ready !== 1'b1) break;
      sample_data = 10'h3ff - 10'h045 * n[9:0];
      sample_valid = 1'b1;
      n++;
    end
    sample_valid = 1'b0;
    check_val("fifo fill", 16'(FIFO_DEPTH), 16'(n));
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      d = 10'h3ff - 10'h045 * i[9:0];
      sadc_host_model_inst.frame(16);
      check_val("frame word", {3'h0, d, 3'h0}, sadc_host_model_inst.word);
      check_val("dummy flag", 16'(i == 0), 16'(result_invalid));
      check_val("track after frame", 16'h0000, 16'(hold_active));
    end
    sadc_host_model_inst.frame(16);
    check_val("repeat word", {3'h0, d, 3'h0}, sadc_host_model_inst.word);
    check_val("missed count", 16'h0001, 16'(n_miss));
    check_val("done count", 16'(FIFO_DEPTH + 1), 16'(n_done));
    $display("test_stream done");
  endtask
  // aborts at falls 5, 1 and 12 walk the mode decisions
  task automatic test_modes();
    int a;
    a = n_abort;
    sadc_host_model_inst.frame(5);
    check_val("mode after 5", 16'h0000, 16'(normal_mode));
    check_val("float after 5", 16'h0001, 16'(serial_result_oe_n));
    repeat (50) @(posedge clk);
    check_val("mode idle", 16'h0000, 16'(normal_mode));
    sadc_host_model_inst.frame(1);
    check_val("mode after 1", 16'h0000, 16'(normal_mode));
    sadc_host_model_inst.frame(16);
    check_val("wake dummy", 16'h0001, 16'(result_invalid));
    check_val("mode after wake", 16'h0001, 16'(normal_mode));
    sadc_host_model_inst.frame(12);
    check_val("mode after 12", 16'h0001, 16'(normal_mode));
    check_val("float after 12", 16'h0001, 16'(serial_result_oe_n));
    sadc_host_model_inst.frame(16);
    check_val("valid again", 16'h0000, 16'(result_invalid));
    check_val("abort count", 16'(a + 3), 16'(n_abort));
    $display("test_modes done");
  endtask
  initial begin
    reset_n = 1'b0;
    sample_valid = 1'b0;
    sample_data = 10'h000;
    repeat (4) @(posedge clk);
    #3;
    reset_n = 1'b1;
    test_stream();
    test_modes();
    stop_test();
  end
endmodule
`default_nettype wire
